// ==== design/osw_consts.svh ====
`ifndef OSW_CONSTS_SVH
`define OSW_CONSTS_SVH

// Core clock rate and the open-load fault filter.
`define OSW_CORE_CLK_MHZ 25
`define OSW_FILTER_MIN_US 100
`define OSW_FILTER_MAX_US 300
`define OSW_FILTER_CYC (`OSW_FILTER_MIN_US * `OSW_CORE_CLK_MHZ)
`define OSW_TIMER_W 12

// Reset values.
`define OSW_CMD_RST 8'h00
`define OSW_FAULT_RST 8'h00
`define OSW_WORD_RST 8'h00

// Bit positions in the synchroniser bundle.
`define OSW_SYNC_W 29
`define OSW_SYNC_RST 29'h1000_0000
`define OSW_SB_CS 28
`define OSW_SB_TOG 27
`define OSW_SB_FRAG 26
`define OSW_SB_VDD_UV 25
`define OSW_SB_VPWR_OV 24
`define OSW_SB_OL 0
`define OSW_SB_OC 8
`define OSW_SB_OT 16

// Bit counter of the serial frame.
`define OSW_BIT_LAST 3'h7
`define OSW_BIT_RST 3'h0

`endif

// ==== design/osw_pkg.sv ====
`default_nettype none

package osw_pkg;
    typedef logic [7:0] chan_vec_t;
    typedef logic [2:0] bit_idx_t;
    typedef logic [11:0] filt_cnt_t;
endpackage : osw_pkg

`default_nettype wire

// ==== design/osw_link_if.sv ====
`default_nettype none

interface osw_link_if;
    import osw_pkg::*;
    chan_vec_t cmd_word;
    logic byte_tog;
    logic frag;
    chan_vec_t tx_word;

    modport link (
        output cmd_word,
        output byte_tog,
        output frag,
        input tx_word
    );
    modport core (
        input cmd_word,
        input byte_tog,
        input frag,
        output tx_word
    );
endinterface : osw_link_if

`default_nettype wire

// ==== design/osw_spi_shift.sv ====
`include "osw_consts.svh"
`default_nettype none

module osw_spi_shift (
    input wire logic i_spi_clk,
    input wire logic i_cs_n,
    input wire logic i_resetn,
    input wire logic i_mosi,
    output logic o_miso,
    osw_link_if.link lk
);
    import osw_pkg::*;

    bit_idx_t bit_r;
    logic first_r;
    logic out_first_r;
    logic out_r;
    chan_vec_t sh_r;
    chan_vec_t hold_r;
    logic tog_r;
    logic frag_r;

    // The fault word sits in the shifter until the first edge, then received bits follow it out.
    wire chan_vec_t cur_word = first_r ? lk.tx_word : sh_r;
    wire chan_vec_t sh_nxt = {cur_word[6:0], i_mosi};
    wire byte_end = (bit_r == `OSW_BIT_LAST);

    // Chip select high clears the frame state, since the link clock stands still between frames.
    always_ff @(posedge i_spi_clk or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            bit_r <= `OSW_BIT_RST;
            first_r <= 1'b1;
        end
        else
        begin
            bit_r <= bit_r + 3'h1;
            first_r <= 1'b0;
        end
    end

    always_ff @(posedge i_spi_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sh_r <= `OSW_WORD_RST;
            hold_r <= `OSW_WORD_RST;
            tog_r <= 1'b0;
            frag_r <= 1'b0;
        end
        else
        begin
            sh_r <= sh_nxt;
            frag_r <= !byte_end;
            if (byte_end)
            begin
                hold_r <= sh_nxt;
                tog_r <= !tog_r;
            end
        end
    end

    always_ff @(negedge i_spi_clk or posedge i_cs_n)
    begin
        if (i_cs_n)
            out_first_r <= 1'b1;
        else
            out_first_r <= 1'b0;
    end

    always_ff @(negedge i_spi_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            out_r <= 1'b0;
        else
            out_r <= sh_r[7];
    end

    assign o_miso = out_first_r ? lk.tx_word[7] : out_r;
    assign lk.cmd_word = hold_r;
    assign lk.byte_tog = tog_r;
    assign lk.frag = frag_r;

    chk_byte_capture:
    assert property (@(posedge i_spi_clk) disable iff (i_cs_n || !i_resetn)
        byte_end |=> (hold_r == sh_r) && !frag_r)
    else $error("Completed byte not captured for the core.");

endmodule : osw_spi_shift

`default_nettype wire

// ==== design/osw_fault_core.sv ====
`include "osw_consts.svh"
`default_nettype none

// Notes on behaviour
// - Open load checked only on commanded-off outputs.
// - Open-load reports filtered for 100 to 300 us.
// - Chip select rise restarts filter; evaluate after expiry.
// - Open-load flag stays latched until read.
// - Thermal limit turns off only that output.
// - Output retries automatically after cooling down.
// - Logic undervoltage: outputs off, fault register cleared.
// - Power undervoltage never shuts down the outputs.
// - Every frame carries exactly eight bits each way; the core also accepts frames of any odd number of whole bytes.
// - Most significant bit first, mapped to channel eight.
// - Command one turns output on, zero off.
// - Fault bit one means that channel faulted.
// - Overcurrent reported; open load while on ignored.
// - Overtemperature sets that output's fault bit.
// - Power overvoltage: all off, then resume commanded state.
// - Command applied on the closing chip select edge.

module osw_fault_core (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_spi_clk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire osw_pkg::chan_vec_t i_open_load_cmp,
    input wire osw_pkg::chan_vec_t i_overcurrent,
    input wire osw_pkg::chan_vec_t i_overtemp,
    input wire logic i_vdd_uv,
    input wire logic i_vpwr_ov,
    output logic o_miso,
    output osw_pkg::chan_vec_t o_channel_drive,
    output osw_pkg::chan_vec_t o_fault_status_reg
);
    import osw_pkg::*;

    osw_link_if lk ();

    osw_spi_shift u_shift (
        .i_spi_clk(i_spi_clk),
        .i_cs_n(i_cs_n),
        .i_resetn(i_resetn),
        .i_mosi(i_mosi),
        .o_miso(o_miso),
        .lk(lk)
    );

    logic [`OSW_SYNC_W-1:0] meta_r;
    logic [`OSW_SYNC_W-1:0] sync_r;
    logic cs_prev_r;
    logic tog_seen_r;
    filt_cnt_t timer_r;
    filt_cnt_t timer_nxt;
    chan_vec_t output_on_off_command_r;
    chan_vec_t output_on_off_command_nxt;
    chan_vec_t per_output_fault_flags_r;
    chan_vec_t per_output_fault_flags_nxt;
    chan_vec_t snap_r;
    chan_vec_t drive_r;
    chan_vec_t drive_nxt;

    // Fault and supply pins, chip select and the toggle and fragment levels pass two flip-flops before the core logic sees them.
    wire [`OSW_SYNC_W-1:0] async_in = {i_cs_n, lk.byte_tog, lk.frag, i_vdd_uv, i_vpwr_ov,
                                       i_overtemp, i_overcurrent, i_open_load_cmp};

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            meta_r <= `OSW_SYNC_RST;
            sync_r <= `OSW_SYNC_RST;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    wire cs_s = sync_r[`OSW_SB_CS];
    wire tog_s = sync_r[`OSW_SB_TOG];
    wire frag_s = sync_r[`OSW_SB_FRAG];
    wire vdd_uv_s = sync_r[`OSW_SB_VDD_UV];
    wire vpwr_ov_s = sync_r[`OSW_SB_VPWR_OV];
    wire chan_vec_t ol_s = sync_r[`OSW_SB_OL +: 8];
    wire chan_vec_t oc_s = sync_r[`OSW_SB_OC +: 8];
    wire chan_vec_t ot_s = sync_r[`OSW_SB_OT +: 8];

    wire cs_rise = cs_s && !cs_prev_r;
    wire cs_fall = !cs_s && cs_prev_r;

    // A frame counts only if it closed on a byte boundary after an odd number of bytes.
    // The held word is read directly: it last changed well before chip select rose.
    wire new_bytes = (tog_s != tog_seen_r);
    wire cmd_apply = cs_rise && new_bytes && !frag_s;

    // Open-load comparators are ignored until the filter timer has run out.
    wire ol_enable = (timer_r == 12'h000);
    wire chan_vec_t ol_set = {8{ol_enable}} & ~output_on_off_command_r & ol_s;
    wire chan_vec_t hot_set = ot_s | (oc_s & output_on_off_command_r);
    wire chan_vec_t fault_set = ol_set | hot_set;
    wire global_off = vdd_uv_s || vpwr_ov_s;

    always_comb
    begin
        if (vdd_uv_s)
            output_on_off_command_nxt = `OSW_CMD_RST;
        else if (cmd_apply)
            output_on_off_command_nxt = lk.cmd_word;
        else
            output_on_off_command_nxt = output_on_off_command_r;
    end

    always_comb
    begin
        if (cs_rise)
            timer_nxt = filt_cnt_t'(`OSW_FILTER_CYC);
        else if (timer_r != 12'h000)
            timer_nxt = timer_r - 12'h001;
        else
            timer_nxt = timer_r;
    end

    // Reading the register clears it, but a fault present in the same cycle sets it again.
    always_comb
    begin
        if (vdd_uv_s)
            per_output_fault_flags_nxt = `OSW_FAULT_RST;
        else if (cs_fall)
            per_output_fault_flags_nxt = fault_set;
        else
            per_output_fault_flags_nxt = per_output_fault_flags_r | fault_set;
    end

    // Command is kept through overvoltage so the outputs resume their previous state.
    // Power undervoltage is deliberately absent here.
    always_comb
    begin
        if (global_off)
            drive_nxt = `OSW_CMD_RST;
        else
            drive_nxt = output_on_off_command_r & ~ot_s;
    end

    // Chip select resets high so that release from reset never looks like a frame edge.
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cs_prev_r <= 1'b1;
            tog_seen_r <= 1'b0;
        end
        else
        begin
            cs_prev_r <= cs_s;
            tog_seen_r <= cs_rise ? tog_s : tog_seen_r;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            timer_r <= 12'h000;
        else
            timer_r <= timer_nxt;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            output_on_off_command_r <= `OSW_CMD_RST;
        else
            output_on_off_command_r <= output_on_off_command_nxt;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            per_output_fault_flags_r <= `OSW_FAULT_RST;
        else
            per_output_fault_flags_r <= per_output_fault_flags_nxt;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            drive_r <= `OSW_CMD_RST;
        else
            drive_r <= drive_nxt;
    end

    // The shifted-out word is frozen for the whole frame so the link side sees a stable bus.
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            snap_r <= `OSW_FAULT_RST;
        else if (cs_prev_r)
            snap_r <= per_output_fault_flags_r;
    end

    assign lk.tx_word = snap_r;
    assign o_channel_drive = drive_r;
    assign o_fault_status_reg = per_output_fault_flags_r;

    sequence frame_close;
        cs_rise && !vdd_uv_s;
    endsequence

    sequence filter_running;
        !ol_enable [*8];
    endsequence

    sequence ov_held;
        vpwr_ov_s [*2];
    endsequence

    sequence filter_expired;
        ol_enable && !vdd_uv_s;
    endsequence

    chk_ol_off_only:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cs_prev_r && !vdd_uv_s && (ol_s & output_on_off_command_r & ~ot_s & ~oc_s) != 8'h00
        |=> (per_output_fault_flags_r & $past(ol_s & output_on_off_command_r & ~ot_s & ~oc_s)
            & ~$past(per_output_fault_flags_r)) == 8'h00)
    else $error("Open load flagged on a channel commanded on.");

    chk_filter_start:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cs_rise |=> (timer_r == filt_cnt_t'(`OSW_FILTER_CYC)) ##0 filter_running)
    else $error("Fault filter not restarted to its full length.");

    chk_filter_mask:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !ol_enable && !vdd_uv_s && !cs_fall && (ot_s | oc_s) == 8'h00
        |=> (per_output_fault_flags_r & ~$past(per_output_fault_flags_r)) == 8'h00)
    else $error("Open load reported while the filter runs.");

    chk_flag_latched:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !cs_fall && !vdd_uv_s |=> ($past(per_output_fault_flags_r) & ~per_output_fault_flags_r) == 8'h00)
    else $error("Fault flag dropped before it was read.");

    chk_thermal_single:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !global_off |=> drive_r == $past(output_on_off_command_r & ~ot_s))
    else $error("Thermal shutdown touched the wrong channels.");

    chk_thermal_retry:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $fell(ot_s[0]) && output_on_off_command_r[0] && !global_off ##1 $stable(output_on_off_command_r[0])
        |-> drive_r[0])
    else $error("Channel did not restart after cooling.");

    chk_vdd_uv:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        vdd_uv_s |=> drive_r == 8'h00 && per_output_fault_flags_r == 8'h00 && output_on_off_command_r == 8'h00)
    else $error("Logic undervoltage left outputs or faults set.");

    chk_cmd_apply:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        frame_close ##0 (new_bytes && !frag_s) |=> output_on_off_command_r == $past(lk.cmd_word))
    else $error("Command not applied at chip select rise.");

    chk_cmd_reject:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !vdd_uv_s && !cmd_apply |=> $stable(output_on_off_command_r))
    else $error("Command changed outside a whole-byte frame.");

    chk_ov_global:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        ov_held |-> drive_r == 8'h00)
    else $error("Overvoltage did not shut down the outputs.");

    chk_ov_resume:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $fell(vpwr_ov_s) && !vdd_uv_s |=> drive_r == $past(output_on_off_command_r & ~ot_s))
    else $error("Outputs did not resume after overvoltage.");

    chk_hot_report:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !vdd_uv_s |=> ($past(ot_s | (oc_s & output_on_off_command_r)) & ~per_output_fault_flags_r) == 8'h00)
    else $error("Overtemperature or overcurrent not flagged.");

    chk_snap_load:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cs_fall |=> snap_r == $past(per_output_fault_flags_r))
    else $error("Shifted fault word not loaded at chip select fall.");

    chk_snap_frozen:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !cs_prev_r |=> $stable(snap_r))
    else $error("Shifted fault word changed inside a frame.");

    chk_timer_count:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !cs_rise && !ol_enable |=> timer_r == $past(timer_r) - 12'h001)
    else $error("Fault filter did not count down.");

    chk_timer_hold:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !cs_rise && ol_enable |=> ol_enable)
    else $error("Fault filter restarted without a chip select rise.");

    chk_ol_report:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        filter_expired |=> ($past(ol_s & ~output_on_off_command_r) & ~per_output_fault_flags_r) == 8'h00)
    else $error("Open load on an idle channel not flagged.");

    chk_global_off:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        global_off |=> drive_r == 8'h00)
    else $error("Outputs left on during a supply shutdown.");

    chk_tog_track:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cs_rise |=> tog_seen_r == $past(tog_s))
    else $error("Byte count not tracked at chip select rise.");

    chk_off_stays_off:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !global_off |=> (drive_r & ~$past(output_on_off_command_r)) == 8'h00)
    else $error("Output driven although commanded off.");

    chk_read_reload:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cs_fall && !vdd_uv_s |=> per_output_fault_flags_r == $past(fault_set))
    else $error("Fault flags not reloaded when the word was read.");

    chk_frag_reject:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cs_rise && frag_s && !vdd_uv_s |=> $stable(output_on_off_command_r))
    else $error("Partial frame changed the command.");

    chk_uv_resume:
    assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $fell(vdd_uv_s) |=> ($past(fault_set) & ~per_output_fault_flags_r) == 8'h00)
    else $error("Fault register did not resume after undervoltage.");

endmodule : osw_fault_core

`default_nettype wire

// ==== tb/osw_host_model.sv ====
`default_nettype none

module osw_host_model
    import osw_pkg::*;
(
    output logic o_spi_clk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    timeunit 1ns;
    timeprecision 100ps;

    // The serial clock stands low between frames.
    initial
    begin
        o_spi_clk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // Sends the low nbits of cmd, most significant first, and returns the bits read back.
    task automatic xfer(input chan_vec_t cmd, input int nbits, output chan_vec_t rsp);
        rsp = 8'h00;
        o_cs_n <= 1'b0;
        #213;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            o_mosi <= cmd[i];
            #80;
            o_spi_clk <= 1'b1;
            rsp = {rsp[6:0], i_miso};
            #80;
            o_spi_clk <= 1'b0;
        end
        #197;
        o_cs_n <= 1'b1;
        // An unselected data line must not keep showing the last bit sent.
        o_mosi <= ~o_mosi;
    endtask : xfer

    // Open-load status is only trustworthy after this spacing between writes.
    task automatic gap();
        #301000;
    endtask : gap
endmodule : osw_host_model

`default_nettype wire

// ==== tb/tb_octal_switch_command_fault_logic.sv ====
`default_nettype none

module tb_octal_switch_command_fault_logic;
    timeunit 1ns;
    timeprecision 100ps;
    import osw_pkg::*;

    logic clk;
    logic resetn;
    logic spi_clk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic vdd_uv;
    logic vpwr_ov;
    chan_vec_t ol;
    chan_vec_t oc;
    chan_vec_t ot;
    chan_vec_t drive;
    chan_vec_t fault;
    chan_vec_t rsp;
    int num_errors = 0;
    int compares = 0;

    osw_fault_core uut (
        .i_core_clk(clk),
        .i_resetn(resetn),
        .i_spi_clk(spi_clk),
        .i_cs_n(cs_n),
        .i_mosi(mosi),
        .i_open_load_cmp(ol),
        .i_overcurrent(oc),
        .i_overtemp(ot),
        .i_vdd_uv(vdd_uv),
        .i_vpwr_ov(vpwr_ov),
        .o_miso(miso),
        .o_channel_drive(drive),
        .o_fault_status_reg(fault)
    );

    osw_host_model host (
        .o_spi_clk(spi_clk),
        .o_cs_n(cs_n),
        .o_mosi(mosi),
        .i_miso(miso)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input chan_vec_t seen, input chan_vec_t exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task automatic t_cmd();
        host.xfer(8'ha5, 8, rsp);
        check(rsp, 8'h00, "idle fault word");
        check(drive, 8'h00, "drive before apply");
        cyc(6);
        check(drive, 8'ha5, "drive after apply");
        host.gap();
        host.xfer(8'h3c, 7, rsp);
        cyc(6);
        check(drive, 8'ha5, "short frame ignored");
    endtask : t_cmd

    task automatic t_thermal();
        @(posedge clk);
        ot <= 8'h01;
        cyc(5);
        check(drive, 8'ha4, "only hot output off");
        check(fault, 8'h01, "thermal flag");
        @(posedge clk);
        ot <= 8'h00;
        cyc(5);
        check(drive, 8'ha5, "retry after cooling");
        host.gap();
        host.xfer(8'ha5, 8, rsp);
        check(rsp, 8'h01, "thermal fault word");
        @(posedge clk);
        oc <= 8'h04;
        cyc(5);
        check(fault, 8'h04, "overcurrent flag");
        @(posedge clk);
        oc <= 8'h00;
        host.gap();
        host.xfer(8'ha5, 8, rsp);
        check(rsp, 8'h04, "overcurrent word");
    endtask : t_thermal

    task automatic t_open_load();
        @(posedge clk);
        ol <= 8'h03;
        cyc(2400);
        check(fault, 8'h00, "filter still running");
        cyc(200);
        check(fault, 8'h02, "open load only when off");
        @(posedge clk);
        ol <= 8'h00;
        cyc(5);
        check(fault, 8'h02, "open load latched");
        host.gap();
        host.xfer(8'ha5, 8, rsp);
        check(rsp, 8'h02, "open load word");
        cyc(5);
        check(fault, 8'h00, "cleared after read");
    endtask : t_open_load

    task automatic t_supply();
        @(posedge clk);
        vpwr_ov <= 1'b1;
        cyc(5);
        check(drive, 8'h00, "overvoltage off");
        @(posedge clk);
        vpwr_ov <= 1'b0;
        cyc(5);
        check(drive, 8'ha5, "overvoltage resume");
        @(posedge clk);
        ot <= 8'h80;
        cyc(5);
        check(fault, 8'h80, "flag before undervoltage");
        @(posedge clk);
        vdd_uv <= 1'b1;
        cyc(5);
        check(drive, 8'h00, "undervoltage off");
        check(fault, 8'h00, "undervoltage clears");
        @(posedge clk);
        vdd_uv <= 1'b0;
        ot <= 8'h00;
        cyc(5);
        host.gap();
        host.xfer(8'h81, 8, rsp);
        check(rsp, 8'h00, "word after recovery");
        cyc(6);
        check(drive, 8'h81, "commands after recovery");
    endtask : t_supply

    initial
    begin
        resetn = 1'b0;
        vdd_uv = 1'b0;
        vpwr_ov = 1'b0;
        ol = 8'h00;
        oc = 8'h00;
        ot = 8'h00;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        cyc(5);
        check(drive, 8'h00, "reset drive");
        check(fault, 8'h00, "reset flags");
        t_cmd();
        t_thermal();
        t_open_load();
        t_supply();
        finish_test();
    end

    // About half as long again as the expected run of about 41000 core cycles.
    initial
    begin
        #(60000 * 40);
        num_errors++;
        finish_test();
    end
endmodule : tb_octal_switch_command_fault_logic

`default_nettype wire
